// [lmc_pkg.sv]
package lmc_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS          = 100;
	localparam int MODE_CHANGE_DELAY_NS   = 15000;
	localparam int RELEASE_HOLD_TIME_NS   = 15000;
	localparam int FLASH_ENTRY_LOW_TIME_NS = 50000;
	localparam int FLASH_EDGE_TIMING_A_NS = 10000;
	localparam int FLASH_EDGE_TIMING_B_NS = 10000;
	localparam int FLASH_EDGE_TIMING_C_NS = 10000;
	localparam int CNT_W                  = 12;

	// least time, rounded up, never below one cycle
	function automatic int cyc_min(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int MODE_CYC = cyc_min(MODE_CHANGE_DELAY_NS);
	localparam int REL_CYC  = cyc_min(RELEASE_HOLD_TIME_NS);
	localparam int FL1_CYC  = cyc_min(FLASH_ENTRY_LOW_TIME_NS);
	localparam int FL2_CYC  = cyc_min(FLASH_EDGE_TIMING_A_NS);
	localparam int FL3_CYC  = cyc_min(FLASH_EDGE_TIMING_B_NS);
	localparam int FL4_RAW  = cyc_min(FLASH_EDGE_TIMING_C_NS);
	// the tail keeps mode-select low for the whole entry low time
	localparam int FL4_CYC  = (FL1_CYC - FL2_CYC - FL3_CYC > FL4_RAW) ?
		(FL1_CYC - FL2_CYC - FL3_CYC) : FL4_RAW;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_SLEEP,
		ST_STANDBY,
		ST_ENTER,
		ST_RELEASE,
		ST_NORMAL,
		ST_FL_LOW,
		ST_FL_TXLO,
		ST_FL_TXHI
	} lmc_state_t;

	typedef enum logic [1:0] {
		MODE_SLEEP,
		MODE_STANDBY,
		MODE_SLOPE,
		MODE_FLASH
	} lmc_mode_t;

	typedef enum logic [1:0] {
		WAKE_NONE,
		WAKE_POWER,
		WAKE_BUS,
		WAKE_LOCAL
	} lmc_wake_t;

	typedef struct packed {
		lmc_state_t         st;
		logic [CNT_W-1:0]   cnt;
		logic               en;
		logic               txd;
		logic               txd_oe_n;
		lmc_mode_t          mode;
		logic               ready;
		lmc_wake_t          wake;
		logic               rx1;
		logic               rx2;
		logic               tx1;
		logic               tx2;
	} lmc_regs_t;

endpackage

// [lmc_host.sv]
// Functional notes
// R1 - raising mode-select puts the device into normal operation, data both ways
// R2 - in normal operation the device keeps regulator output high, termination on
// R3 - any entry to normal operation lands in normal-slope sub-mode
// R4 - flash mode may only be entered from normal-slope mode
// R5 - output stage recessive during mode change until transmit high for release time
// R6 - host holds transmit high for the release time after each mode change
// R7 - normal-slope mode carries data up to 20 kBaud, slew controlled
// R8 - normal-slope entry completes a fixed delay after mode-select high
// R9 - flash mode keeps data flowing with slew control off
// R10 - flash entry: mode-select low, transmit falls then rises in the timing window
// R11 - same sequence in flash returns to normal-slope, release applies again
// R12 - mode-select low in flash without transmit edges sends device to sleep
// R13 - stand-by follows power-up, power-on reset, bus wake or local wake
// R14 - stand-by: output stage off, termination on, regulator output high
// R15 - stand-by receive pin low after a wake, high after power-up
// R16 - stand-by transmit pin: weak pull-down bus wake, strong local wake
// R17 - host pulls transmit pin high in stand-by and senses the pull-down
// R18 - wake indications clear on change to normal; mode-select high does it
// R19 - host drives mode-select low to move normal operation to sleep
// R20 - sleep: receiver, output stage, terminations and regulator output off
// R21 - sleep keeps wake detection; wake goes stand-by, mode-select high normal
// R22 - bus wake needs filtered dominant then recessive; local wake filtered low
// R23 - after qualified dominant the device stays asleep until recessive returns
// R24 - local wake input is active low, falling-edge triggered, pulled up
// R25 - transmit edges in the window mean flash toggle, else a sleep request
// R26 - power-up shows in stand-by only without wake; later wake updates it
module lmc_host
	import lmc_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic        req_normal_i,
	input  wire logic        req_sleep_i,
	input  wire logic        req_flash_i,
	input  wire logic        user_txd_i,
	input  wire logic        rxd_pin_i,
	input  wire logic        txd_pin_i,
	output logic             en_o,
	output logic             txd_o,
	output logic             txd_oe_n_o,
	output logic             rxd_o,
	output logic             ready_o,
	output logic [1:0]       mode_o,
	output logic [1:0]       wake_src_o
);

	lmc_regs_t s;
	lmc_regs_t next_s;

	function automatic logic [CNT_W-1:0] load(input int n);
		return CNT_W'(n - 1);
	endfunction

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		next_s     = s;
		next_s.rx1 = rxd_pin_i;
		next_s.rx2 = s.rx1;
		next_s.tx1 = txd_pin_i;
		next_s.tx2 = s.tx1;
		if (s.cnt != '0)
		begin
			next_s.cnt = s.cnt - 1'b1;
		end
		case (s.st)
			ST_SLEEP:
			begin
				if (req_normal_i)
				begin
					next_s.en       = 1'b1;  // [R21] [R1]
					next_s.txd      = 1'b1;
					next_s.txd_oe_n = 1'b0;
					next_s.cnt      = load(MODE_CYC);
					next_s.st       = ST_ENTER;
				end
				else if (!s.rx2)
				begin
					// receive low only after a qualified wake [R23] [R13]
					next_s.st   = ST_STANDBY;
					next_s.mode = MODE_STANDBY;
				end
			end
			ST_STANDBY:
			begin
				// pin released so the pull-up meets the pull-down [R17]
				next_s.txd_oe_n = 1'b1;  // [R14]
				if (!s.tx2)
				begin
					next_s.wake = WAKE_LOCAL;  // [R16] [R26]
				end
				else if (!s.rx2)
				begin
					next_s.wake = WAKE_BUS;  // [R15] [R26]
				end
				else if (s.wake == WAKE_NONE)
				begin
					next_s.wake = WAKE_POWER;
				end
				if (req_normal_i)
				begin
					next_s.en       = 1'b1;  // [R18] [R1]
					next_s.txd      = 1'b1;
					next_s.txd_oe_n = 1'b0;
					next_s.cnt      = load(MODE_CYC);
					next_s.st       = ST_ENTER;
				end
			end
			ST_ENTER:
			begin
				if (s.cnt == '0)
				begin
					// en stays high, keeping the regulator output on [R2]
					next_s.mode = MODE_SLOPE;  // [R3] [R8]
					next_s.wake = WAKE_NONE;   // [R18]
					next_s.cnt  = load(REL_CYC);
					next_s.st   = ST_RELEASE;
				end
			end
			ST_RELEASE:
			begin
				// transmit held high so the device releases its stage [R5] [R6]
				if (s.cnt == '0)
				begin
					next_s.ready = 1'b1;
					next_s.txd   = user_txd_i;
					next_s.st    = ST_NORMAL;
				end
			end
			ST_NORMAL:
			begin
				next_s.txd = user_txd_i;  // [R1] [R7] [R9]
				if (req_sleep_i)
				begin
					next_s.en       = 1'b0;  // [R19] [R12] [R20]
					next_s.ready    = 1'b0;
					next_s.txd_oe_n = 1'b1;
					next_s.mode     = MODE_SLEEP;
					next_s.st       = ST_SLEEP;
				end
				else if (req_flash_i)
				begin
					next_s.en    = 1'b0;  // [R10] [R25]
					next_s.ready = 1'b0;
					next_s.txd   = 1'b1;
					next_s.cnt   = load(FL2_CYC);
					next_s.st    = ST_FL_LOW;
				end
			end
			ST_FL_LOW:
			begin
				if (s.cnt == '0)
				begin
					next_s.txd = 1'b0;  // [R10]
					next_s.cnt = load(FL3_CYC);
					next_s.st  = ST_FL_TXLO;
				end
			end
			ST_FL_TXLO:
			begin
				if (s.cnt == '0)
				begin
					next_s.txd = 1'b1;  // [R10]
					next_s.cnt = load(FL4_CYC);
					next_s.st  = ST_FL_TXHI;
				end
			end
			ST_FL_TXHI:
			begin
				if (s.cnt == '0)
				begin
					next_s.en   = 1'b1;
					// flash only from slope, same sequence returns [R4] [R11]
					next_s.mode = (s.mode == MODE_SLOPE) ? MODE_FLASH : MODE_SLOPE;
					next_s.cnt  = load(REL_CYC);
					next_s.st   = ST_RELEASE;
				end
			end
			default:
			begin
				next_s.st = ST_STANDBY;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			s          <= '0;
			s.st       <= ST_STANDBY;  // [R13] [R24]
			s.mode     <= MODE_STANDBY;
			s.txd      <= 1'b1;
			s.txd_oe_n <= 1'b1;
			s.rx1      <= 1'b1;
			s.rx2      <= 1'b1;
			s.tx1      <= 1'b1;
			s.tx2      <= 1'b1;
		end
		else
		begin
			s <= next_s;
		end
	end

	assign en_o       = s.en;
	assign txd_o      = s.txd;
	assign txd_oe_n_o = s.txd_oe_n;
	assign rxd_o      = s.rx2;  // [R22]
	assign ready_o    = s.ready;
	assign mode_o     = s.mode;
	assign wake_src_o = s.wake;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	localparam int A_MODE = MODE_CYC;
	logic [CNT_W-1:0] hi_cnt;

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i || s.txd_oe_n || !s.txd)
		begin
			hi_cnt <= '0;
		end
		else if (hi_cnt != '1)
		begin
			hi_cnt <= hi_cnt + 1'b1;
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	a_enter_en_high: assert property ( // [R1]
		(s.st == ST_STANDBY || s.st == ST_SLEEP) && req_normal_i |=> en_o)
		else $error("mode-select not raised on normal request");
	a_mode_delay: assert property ( // [R8]
		$rose(s.st == ST_ENTER) |-> ##A_MODE s.st == ST_RELEASE)
		else $error("mode change delay wrong");
	a_release_hold: assert property ( // [R6]
		$rose(ready_o) |-> hi_cnt >= CNT_W'(REL_CYC))
		else $error("transmit not held high for release time");
	a_standby_free: assert property ( // [R17]
		s.st == ST_STANDBY |-> txd_oe_n_o)
		else $error("transmit driven in stand-by");
	a_sleep_req: assert property ( // [R19]
		s.st == ST_NORMAL && req_sleep_i |=> !en_o && mode_o == MODE_SLEEP)
		else $error("sleep request not carried out");
	a_flash_from: assert property ( // [R4]
		$rose(mode_o == MODE_FLASH) |-> $past(mode_o) == MODE_SLOPE)
		else $error("flash entered from wrong mode");
	a_flash_edge: assert property ( // [R10]
		s.st == ST_FL_LOW && s.cnt == '0 |=> !txd_o && !en_o ##1 !txd_o)
		else $error("flash falling edge missing");
	a_wake_bus: assert property ( // [R16]
		s.st == ST_STANDBY && s.tx2 && !s.rx2 && !req_normal_i
		|=> wake_src_o == WAKE_BUS)
		else $error("bus wake not reported");
	a_sleep_wake: assert property ( // [R21]
		s.st == ST_SLEEP && !s.rx2 && !req_normal_i |=> mode_o == MODE_STANDBY)
		else $error("wake in sleep not followed");
	a_data_pass: assert property ( // [R1]
		ready_o && $past(ready_o) && s.st == ST_NORMAL
		|-> txd_o == $past(user_txd_i))
		else $error("transmit data not forwarded");

	c_flash_in:  cover property ($rose(mode_o == MODE_FLASH));
	c_flash_out: cover property ($fell(mode_o == MODE_FLASH) && mode_o == MODE_SLOPE);
	c_wake:      cover property (s.st == ST_SLEEP ##1 s.st == ST_STANDBY);
	c_ready:     cover property ($rose(ready_o));

endmodule

// [lmc_dev_model.sv]
module lmc_dev_model
	import lmc_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic en_i,
	input  wire logic txd_i,
	input  wire logic bus_wake_i,
	input  wire logic local_wake_i,
	output logic      rxd_o,
	output logic      strong_pd_o,
	output logic      regulator_control_output_o,
	output logic      flash_o
);
	timeunit 1ns;
	timeprecision 1ns;

	typedef enum logic [1:0] {D_SLEEP, D_STBY, D_NORM} lmc_dmode_t;

	// power-up lands in stand-by with no wake flag
	lmc_dmode_t md   = D_STBY;
	logic [1:0] flag = 2'h0;
	logic       en_q = 1'b0;
	logic       flash_q   = 1'b0;
	logic       from_norm = 1'b0;
	logic       tx_q      = 1'b1;
	logic       fell_q    = 1'b0;
	logic       rose_q    = 1'b0;
	logic [9:0] lo_cnt    = 10'h0;

	always @(posedge clk_i)
	begin
		en_q <= en_i;
		tx_q <= txd_i;
		// watch the transmit edges while mode-select is low
		if (en_i)
		begin
			lo_cnt <= 10'h0;
			fell_q <= 1'b0;
			rose_q <= 1'b0;
		end
		else
		begin
			if (lo_cnt != 10'h3ff)
				lo_cnt <= lo_cnt + 10'h1;
			if (tx_q && !txd_i)
				fell_q <= 1'b1;
			if (fell_q && !tx_q && txd_i)
				rose_q <= 1'b1;
		end
		if (en_i && !en_q)
		begin
			md   <= D_NORM;
			flag <= 2'h0;
			flash_q <= from_norm && rose_q &&
				(lo_cnt >= 10'(FL1_CYC)) && !flash_q;
		end
		else if (!en_i && en_q)
		begin
			from_norm <= (md == D_NORM);
			md <= D_SLEEP;
		end
		else if (md == D_SLEEP && (bus_wake_i || local_wake_i))
		begin
			// bus wake pulse stands for dominant then recessive
			md   <= D_STBY;
			flag <= local_wake_i ? 2'h2 : 2'h1;
		end
	end

	assign rxd_o = (md == D_NORM) ? txd_i :
		(md == D_STBY && flag != 2'h0) ? 1'b0 : 1'b1;
	assign strong_pd_o = (md == D_STBY) && (flag == 2'h2);
	assign regulator_control_output_o = (md != D_SLEEP);
	assign flash_o = flash_q && (md == D_NORM);
endmodule

// [lin_transceiver_mode_control_tb_top.sv]
module lin_transceiver_mode_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic       rq_n = 1'b0;
	logic       rq_s = 1'b0;
	logic       rq_f = 1'b0;
	logic       utx = 1'b1;
	logic       bw = 1'b0;
	logic       lw = 1'b0;
	logic       en, txd, oe_n, rxd, rdy, rxd_pin, spd, txd_pin;
	logic       reg_on, fl;
	logic [1:0] mode, wsrc, mprev;
	logic [1:0] q[$];
	int         error_cnt = 0;
	int         checks = 0;
	int         seed = 32'hb09a481e;

	initial forever #50 clk = ~clk;

	// with the host released, the external pull-up loses only to the strong pull-down
	assign txd_pin = !oe_n ? txd : !spd;

	lmc_host lmc_host_inst (.ref_clk_i(clk), .rst_i(rst), .req_normal_i(rq_n),
		.req_sleep_i(rq_s), .req_flash_i(rq_f), .user_txd_i(utx),
		.rxd_pin_i(rxd_pin), .txd_pin_i(txd_pin), .en_o(en), .txd_o(txd),
		.txd_oe_n_o(oe_n), .rxd_o(rxd), .ready_o(rdy), .mode_o(mode),
		.wake_src_o(wsrc));

	lmc_dev_model lmc_dev_model_inst (.clk_i(clk), .en_i(en), .txd_i(txd_pin),
		.bus_wake_i(bw), .local_wake_i(lw), .rxd_o(rxd_pin),
		.strong_pd_o(spd), .regulator_control_output_o(reg_on),
		.flash_o(fl));

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(string n, logic [1:0] e, logic [1:0] g);
		checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic cmd(int k, logic [1:0] m);
		q.push_back(m);
		@(negedge clk);
		{rq_n, rq_s, rq_f} = 3'h4 >> k;
		@(negedge clk);
		{rq_n, rq_s, rq_f} = 3'h0;
	endtask

	task automatic wait_rdy();
		int i;
		for (i = 0; i < 3000 && rdy !== 1'b1; i++)
			@(negedge clk);
		chk("ready_o", 2'h1, {1'b0, rdy});
	endtask

	task automatic wait_mode(logic [1:0] m);
		int i;
		for (i = 0; i < 200 && mode !== m; i++)
			@(negedge clk);
		repeat (5) @(negedge clk);
	endtask

	task automatic data(int n);
		logic b;
		repeat (n)
		begin
			b = 1'($random(seed));
			@(negedge clk);
			utx = b;
			repeat (8) @(negedge clk);
			chk("rxd_o", {1'b0, b}, {1'b0, rxd});
		end
		utx = 1'b1;
	endtask

	task automatic wake(logic loc);
		@(negedge clk);
		{lw, bw} = {loc, !loc};
		@(negedge clk);
		{lw, bw} = 2'h0;
		wait_mode(2'h1);
	endtask

	// ------------------------------------------------------------
	// mode scoreboard
	// ------------------------------------------------------------
	always @(negedge clk)
	begin
		if (!rst && mode !== mprev)
			chk("mode_o", q.size() ? q.pop_front() : 2'hx, mode);
		mprev <= mode;
	end

	initial
	begin
		#(100 * 20000);
		error_cnt++;
		conclude();
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial
	begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		chk("wake_src_o", 2'h1, wsrc);
		chk("rxd_o", 2'h1, {1'b0, rxd});
		chk("regulator", 2'h1, {1'b0, reg_on});
		$display("test powerup done");
		@(negedge clk);
		rq_f = 1'b1;
		@(negedge clk);
		rq_f = 1'b0;
		repeat (40) @(negedge clk);
		chk("mode_o", 2'h1, mode);
		$display("test flash refused done");
		cmd(0, 2'h2);
		wait_rdy();
		chk("wake_src_o", 2'h0, wsrc);
		chk("regulator", 2'h1, {1'b0, reg_on});
		data(8);
		$display("test normal done");
		cmd(2, 2'h3);
		wait_rdy();
		chk("flash", 2'h1, {1'b0, fl});
		data(4);
		cmd(2, 2'h2);
		wait_rdy();
		chk("flash", 2'h0, {1'b0, fl});
		data(2);
		$display("test flash done");
		cmd(1, 2'h0);
		repeat (3) @(negedge clk);
		chk("txd_oe_n_o", 2'h1, {1'b0, oe_n});
		chk("regulator", 2'h0, {1'b0, reg_on});
		q.push_back(2'h1);
		wake(1'b1);
		chk("wake_src_o", 2'h3, wsrc);
		cmd(0, 2'h2);
		wait_rdy();
		chk("wake_src_o", 2'h0, wsrc);
		$display("test local wake done");
		cmd(1, 2'h0);
		q.push_back(2'h1);
		wake(1'b0);
		chk("wake_src_o", 2'h2, wsrc);
		$display("test bus wake done");
		cmd(0, 2'h2);
		wait_rdy();
		cmd(1, 2'h0);
		repeat (10) @(negedge clk);
		cmd(0, 2'h2);
		wait_rdy();
		data(2);
		$display("test sleep to normal done");
		conclude();
	end
endmodule
